// File: src/art_pkg.sv
// Purpose: Shared constants and types for the auto-reload timer with capture.
// Assumes: Registers sit on an 8-bit special function register bus.
// Notes: Every address, bit position, reset value and count is named here.

// ****************************************************************
// Package
// ****************************************************************
package art_pkg;
  // Register addresses on the special function register bus.
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;
  localparam logic [7:0] ADDR_SHARED_CLOCK_CONTROL = 8'h8E;

  // Bit positions in the timer control register.
  localparam int BIT_HIGH_OVERFLOW_FLAG = 7;
  localparam int BIT_LOW_OVERFLOW_FLAG = 6;
  localparam int BIT_LOW_BYTE_IRQ_ENABLE = 5;
  localparam int BIT_CAPTURE_ENABLE = 4;
  localparam int BIT_SPLIT_MODE_SELECT = 3;
  localparam int BIT_RUN_CONTROL = 2;
  localparam int BIT_UNUSED = 1;
  localparam int BIT_ALTERNATE_CLOCK_SELECT = 0;

  // Bit positions in the shared clock control register.
  localparam int BIT_HIGH_BYTE_SYSTEM_CLOCK_SELECT = 5;
  localparam int BIT_LOW_BYTE_SYSTEM_CLOCK_SELECT = 4;

  // Writable bits of the timer control register; the unused bit is masked.
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hFD;

  // Reset values.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_CLOCK_SELECTS = 2'h0;
  localparam logic [3:0] RESET_PRESCALE = 4'h0;

  // Wrap points.
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;

  // The slow count source is the system clock divided by this figure.
  localparam int PRESCALE_DIVISOR = 12;
  localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIVISOR - 1);

  // Whole state of the timer.
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] reload_low;
    logic [7:0] reload_high;
    logic [7:0] count_low;
    logic [7:0] count_high;
    logic [1:0] clock_selects;
    logic [3:0] prescale;
    logic [7:0] read_data;
  } art_state_s;
endpackage

// File: src/art_sync.sv
// Purpose: Brings the external divided clock into the system clock domain.
// Assumes: The external source is slow compared with the system clock.
// Notes: The first flop feeds only the second; edges come from later flops.

`timescale 1ns/1ps

// ****************************************************************
// Synchroniser with edge detection
// ****************************************************************
module art_sync
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Asynchronous level in.
  input wire logic async_in,
  // Synchronised edges out.
  output logic rise_pulse,
  output logic fall_pulse
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // Two-flop synchroniser followed by one flop for edge detection.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edges are seen only on the settled stages.
  assign rise_pulse = sync_r & ~prev_r;
  assign fall_pulse = ~sync_r & prev_r;
endmodule // art_sync

// File: src/art_timer.sv
// Purpose: 16-bit or split dual 8-bit auto-reload timer with capture.
// Assumes: Bus inputs are synchronous to CLK; reads answer one cycle later.
// Notes: The block claims its own addresses; the bus ORs all read data.

`timescale 1ns/1ps

// Function
// - Unsplit: 16-bit count, reload and high flag on wrap.
// - High flag raises interrupt when timer enabled.
// - Unsplit low wrap interrupts when low enable set.
// - Split: two 8-bit timers with own reloads.
// - Run gates whole timer, or only high byte.
// - Per-byte clock: system_clock, system_clock/12, external/8.
// - External divided clock synchronised before use.
// - High and low wraps set their flags always.
// - Split: high interrupts; low too when enabled.
// - Flags cleared only by software writes.
// - Capture copies count to reload on falling edge.
// - Control bit 1 reads zero, ignores writes.
// - Control bit order fixed from bit 7 down.
// - Byte clock selects live in shared clock register.
module art_timer
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic RESETN,
  // Special function register bus.
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_RD,
  output logic [7:0] SFR_RDATA,
  // External oscillator divided by eight.
  input wire logic EXT_DIV8_CLK,
  // Timer interrupt enable from the interrupt enable register.
  input wire logic TIMER_IRQ_ENABLE,
  // Interrupt request.
  output logic IRQ_REQ
);
  art_pkg::art_state_s s_r;
  art_pkg::art_state_s s_nxt;
  logic ext_rise;
  logic ext_fall;
  logic split;
  logic run;
  logic low_sel;
  logic high_sel;
  logic xclk;
  logic pre_tick;
  logic tick_low;
  logic tick_high;
  logic low_wrap;
  logic high_wrap;
  logic full_wrap;
  logic [15:0] count16;
  logic [15:0] reload16;
  logic [15:0] count16_inc;
  logic capture;

  // Returns one when a write of this cycle targets the given address.
  function automatic logic wr_hit(input logic [7:0] a);
    return SFR_WR && (SFR_ADDR == a);
  endfunction

  // Chooses one byte's tick from its system_clock select and the alternate select.
  function automatic logic byte_tick(input logic sys_sel, input logic alt,
                                     input logic pre, input logic ext);
    return sys_sel ? 1'b1 : (alt ? ext : pre);
  endfunction

  // ****************************************************************
  // External clock synchroniser
  // ****************************************************************
  // The divided oscillator enters through two flops before any use.
  art_sync u_sync
  (
    .clk(CLK),
    .resetn(RESETN),
    .async_in(EXT_DIV8_CLK),
    .rise_pulse(ext_rise),
    .fall_pulse(ext_fall)
  );

  // ****************************************************************
  // Mode decode and tick selection
  // ****************************************************************
  // Control fields and the per-byte tick sources.
  always_comb
  begin
    split = s_r.control[art_pkg::BIT_SPLIT_MODE_SELECT];
    run = s_r.control[art_pkg::BIT_RUN_CONTROL];
    xclk = s_r.control[art_pkg::BIT_ALTERNATE_CLOCK_SELECT];
    low_sel = s_r.clock_selects[0];
    // The high select matters only in split mode.
    high_sel = split ? s_r.clock_selects[1] : low_sel;
    pre_tick = (s_r.prescale == art_pkg::PRESCALE_LAST);
    tick_low = byte_tick(low_sel, xclk, pre_tick, ext_rise);
    tick_high = byte_tick(high_sel, xclk, pre_tick, ext_rise);
    count16 = {s_r.count_high, s_r.count_low};
    reload16 = {s_r.reload_high, s_r.reload_low};
    count16_inc = count16 + 16'h0001;
    capture = s_r.control[art_pkg::BIT_CAPTURE_ENABLE] && ext_fall;
  end

  // Wrap events for each mode.
  always_comb
  begin
    full_wrap = !split && run && tick_low && (count16 == {2{art_pkg::BYTE_ALL_ONES}});
    if (split)
    begin
      // The low byte runs whatever the run bit says.
      low_wrap = tick_low && (s_r.count_low == art_pkg::BYTE_ALL_ONES);
      high_wrap = run && tick_high && (s_r.count_high == art_pkg::BYTE_ALL_ONES);
    end
    else
    begin
      low_wrap = run && tick_low && (s_r.count_low == art_pkg::BYTE_ALL_ONES);
      high_wrap = full_wrap;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Counting, reloading, capture, flags and bus writes.
  always_comb
  begin
    s_nxt = s_r;
    // Prescaler for the system clock divided by twelve.
    s_nxt.prescale = pre_tick ? art_pkg::RESET_PRESCALE : s_r.prescale + 4'h1;

    // Counting; a stopped section keeps its value.
    if (!split)
    begin
      if (run && tick_low)
      begin
        if (full_wrap)
        begin
          {s_nxt.count_high, s_nxt.count_low} = reload16;
        end
        else
        begin
          {s_nxt.count_high, s_nxt.count_low} = count16_inc;
        end
      end
    end
    else
    begin
      if (tick_low)
      begin
        s_nxt.count_low = low_wrap ? s_r.reload_low : s_r.count_low + 8'h01;
      end
      if (run && tick_high)
      begin
        s_nxt.count_high = high_wrap ? s_r.reload_high : s_r.count_high + 8'h01;
      end
    end

    // Capture copies the count into the reload pair.
    if (capture)
    begin
      s_nxt.reload_high = s_r.count_high;
      s_nxt.reload_low = s_r.count_low;
    end

    // Software writes act at once and take priority over counting.
    if (wr_hit(art_pkg::ADDR_TIMER_CONTROL))
    begin
      s_nxt.control = SFR_WDATA & art_pkg::CONTROL_WRITE_MASK;
    end
    if (wr_hit(art_pkg::ADDR_RELOAD_LOW))
    begin
      s_nxt.reload_low = SFR_WDATA;
    end
    if (wr_hit(art_pkg::ADDR_RELOAD_HIGH))
    begin
      s_nxt.reload_high = SFR_WDATA;
    end
    if (wr_hit(art_pkg::ADDR_COUNT_LOW))
    begin
      s_nxt.count_low = SFR_WDATA;
    end
    if (wr_hit(art_pkg::ADDR_COUNT_HIGH))
    begin
      s_nxt.count_high = SFR_WDATA;
    end
    if (wr_hit(art_pkg::ADDR_SHARED_CLOCK_CONTROL))
    begin
      s_nxt.clock_selects = {SFR_WDATA[art_pkg::BIT_HIGH_BYTE_SYSTEM_CLOCK_SELECT],
                             SFR_WDATA[art_pkg::BIT_LOW_BYTE_SYSTEM_CLOCK_SELECT]};
    end

    // Hardware sets win over a software clear in the same cycle.
    if (high_wrap || capture)
    begin
      s_nxt.control[art_pkg::BIT_HIGH_OVERFLOW_FLAG] = 1'b1;
    end
    if (low_wrap || full_wrap)
    begin
      s_nxt.control[art_pkg::BIT_LOW_OVERFLOW_FLAG] = 1'b1;
    end

    // Registered read data; addresses not owned read as zero.
    s_nxt.read_data = art_pkg::RESET_BYTE;
    if (SFR_RD)
    begin
      case (SFR_ADDR)
        art_pkg::ADDR_TIMER_CONTROL: s_nxt.read_data = s_r.control;
        art_pkg::ADDR_RELOAD_LOW: s_nxt.read_data = s_r.reload_low;
        art_pkg::ADDR_RELOAD_HIGH: s_nxt.read_data = s_r.reload_high;
        art_pkg::ADDR_COUNT_LOW: s_nxt.read_data = s_r.count_low;
        art_pkg::ADDR_COUNT_HIGH: s_nxt.read_data = s_r.count_high;
        art_pkg::ADDR_SHARED_CLOCK_CONTROL:
        begin
          s_nxt.read_data[art_pkg::BIT_HIGH_BYTE_SYSTEM_CLOCK_SELECT] = s_r.clock_selects[1];
          s_nxt.read_data[art_pkg::BIT_LOW_BYTE_SYSTEM_CLOCK_SELECT] = s_r.clock_selects[0];
        end
        default: s_nxt.read_data = art_pkg::RESET_BYTE;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Synchronous reset to documented values.
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      s_r.control <= art_pkg::RESET_BYTE;
      s_r.reload_low <= art_pkg::RESET_BYTE;
      s_r.reload_high <= art_pkg::RESET_BYTE;
      s_r.count_low <= art_pkg::RESET_BYTE;
      s_r.count_high <= art_pkg::RESET_BYTE;
      s_r.clock_selects <= art_pkg::RESET_CLOCK_SELECTS;
      s_r.prescale <= art_pkg::RESET_PRESCALE;
      s_r.read_data <= art_pkg::RESET_BYTE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Interrupt request follows the sticky flags and enables.
  assign IRQ_REQ = TIMER_IRQ_ENABLE &&
                   (s_r.control[art_pkg::BIT_HIGH_OVERFLOW_FLAG] ||
                    (s_r.control[art_pkg::BIT_LOW_BYTE_IRQ_ENABLE] &&
                     s_r.control[art_pkg::BIT_LOW_OVERFLOW_FLAG]));
  assign SFR_RDATA = s_r.read_data;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic no_wr;
  assign no_wr = !SFR_WR;

  // Capture request and its result one cycle on.
  sequence s_capt_req;
    capture && no_wr;
  endsequence
  sequence s_capt_done;
    ##1 ({s_r.reload_high, s_r.reload_low} == $past(count16)) &&
        s_r.control[art_pkg::BIT_HIGH_OVERFLOW_FLAG];
  endsequence

  a_full_wrap_reload: assert property (@(posedge CLK) disable iff (!RESETN)
    (full_wrap && no_wr && !capture) |=>
      (count16 == $past(reload16)) && s_r.control[art_pkg::BIT_HIGH_OVERFLOW_FLAG])
    else $error("16-bit wrap did not reload and flag");

  a_irq_high_flag: assert property (@(posedge CLK) disable iff (!RESETN)
    (TIMER_IRQ_ENABLE && s_r.control[art_pkg::BIT_HIGH_OVERFLOW_FLAG]) |-> IRQ_REQ)
    else $error("high flag did not raise interrupt");

  a_irq_low_flag: assert property (@(posedge CLK) disable iff (!RESETN)
    (low_wrap && no_wr && TIMER_IRQ_ENABLE &&
     s_r.control[art_pkg::BIT_LOW_BYTE_IRQ_ENABLE]) |=> IRQ_REQ)
    else $error("low wrap did not raise interrupt");

  a_irq_gated_off: assert property (@(posedge CLK) disable iff (!RESETN)
    !TIMER_IRQ_ENABLE |-> !IRQ_REQ)
    else $error("interrupt raised while disabled");

  a_split_low_runs: assert property (@(posedge CLK) disable iff (!RESETN)
    (split && !run && tick_low && no_wr && !low_wrap) |=>
      s_r.count_low == $past(s_r.count_low) + 8'h01)
    else $error("split low byte did not count while stopped");

  a_stop_holds: assert property (@(posedge CLK) disable iff (!RESETN)
    (!split && !run && no_wr && !capture)[*2] |-> $stable(count16))
    else $error("stopped timer changed count");

  a_flag_sticky: assert property (@(posedge CLK) disable iff (!RESETN)
    (s_r.control[art_pkg::BIT_LOW_OVERFLOW_FLAG] && no_wr) |=>
      s_r.control[art_pkg::BIT_LOW_OVERFLOW_FLAG])
    else $error("low flag cleared by hardware");

  a_capture_copy: assert property (@(posedge CLK) disable iff (!RESETN)
    s_capt_req |-> s_capt_done)
    else $error("capture did not copy count");

  a_unused_zero: assert property (@(posedge CLK) disable iff (!RESETN)
    (SFR_RD && SFR_ADDR == art_pkg::ADDR_TIMER_CONTROL) |=>
      !SFR_RDATA[art_pkg::BIT_UNUSED])
    else $error("unused control bit read as one");

  a_system_clock_step: assert property (@(posedge CLK) disable iff (!RESETN)
    (!split && run && low_sel && !full_wrap && no_wr && !capture) |=>
      count16 == $past(count16_inc))
    else $error("system clock count did not step by one");
endmodule // art_timer

// File: tb/art_timer_test.sv
// Purpose: Self-checking bench for the auto-reload timer with capture.
// Assumes: Inputs change on the falling edge; read data is valid one cycle later.
// Notes: Random values come from a fixed-seed shift register function.

`timescale 1ns/1ps

// ****************************************************************
// Testbench
// ****************************************************************
module art_timer_test;
  // Design connections; all inputs given a value at time zero, outputs driven by the design.
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic ext_div8_clk = 1'b0;
  logic timer_irq_enable = 1'b0;
  logic irq_req;
  // Bench state.
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'hE2FD;
  logic [7:0] v;
  logic [15:0] c16;
  logic [15:0] r16;
  // Registers checked for their reset value, with one unmapped place last.
  logic [7:0] reset_addrs [7] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'h8E, 8'hC9};

  art_timer dut_u
  (
    .CLK(clk),
    .RESETN(resetn),
    .SFR_ADDR(sfr_addr),
    .SFR_WR(sfr_wr),
    .SFR_WDATA(sfr_wdata),
    .SFR_RD(sfr_rd),
    .SFR_RDATA(sfr_rdata),
    .EXT_DIV8_CLK(ext_div8_clk),
    .TIMER_IRQ_ENABLE(timer_irq_enable),
    .IRQ_REQ(irq_req)
  );

  // The system clock runs at 125 MHz.
  always #4 clk = ~clk;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Next state of the random source.
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [7:0] rnd8();
    seed = lfsr_next(seed);
    return seed[7:0];
  endfunction

  // Flags and count after exactly one tick of the running sections.
  function automatic logic [17:0] exp_step(input logic split, input logic [15:0] c,
      input logic [15:0] r);
    logic [15:0] n;
    logic hf;
    logic lf;
    if (split)
    begin
      hf = (c[15:8] == 8'hFF);
      n = {hf ? r[15:8] : c[15:8] + 8'h01, c[7:0]};
      lf = 1'b0;
    end
    else
    begin
      hf = (c == 16'hFFFF);
      n = hf ? r : c + 16'h0001;
      lf = (c[7:0] == 8'hFF);
    end
    return {hf, lf, n};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Bus tasks start and end at a falling edge, so writes can run back to back.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_rd = 1'b0;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
  endtask

  task automatic idle();
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    @(negedge clk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    sfr_wr = 1'b0;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    chk($sformatf("register %h", a), exp, sfr_rdata);
  endtask

  // One counting edge between a run write and the stop write right after it.
  task automatic one_tick(input logic split, input logic lie, input logic ie,
      input logic hsel, input logic [15:0] c, input logic [15:0] r);
    logic [17:0] e;
    logic [7:0] ctl;
    e = exp_step(split, c, r);
    ctl = {2'b00, lie, 1'b0, split, 3'b001};
    timer_irq_enable = ie;
    // Stop everything first, so a split low byte left running cannot tick here.
    wr(8'hC8, 8'h01);
    wr(8'h8E, split ? 8'h20 : {2'b00, hsel, 5'h10});
    wr(8'hCA, r[7:0]);
    wr(8'hCB, r[15:8]);
    wr(8'hCC, c[7:0]);
    wr(8'hCD, c[15:8]);
    wr(8'hC8, ctl | 8'h04);
    wr(8'hC8, ctl);
    idle();
    chk("interrupt request", {7'h00, ie & (e[17] | (lie & e[16]))}, {7'h00, irq_req});
    rchk(8'hCC, e[7:0]);
    rchk(8'hCD, e[15:8]);
    rchk(8'hC8, {e[17:16], ctl[5:0]});
  endtask

  // Cuts a hang short.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      $display("unexpected run length: expected under 5000 cycles, seen 5000");
      tally_and_finish();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    idle();
    // Reset values, including an unmapped place.
    foreach (reset_addrs[i])
      rchk(reset_addrs[i], 8'h00);
    // Field layout, unused bit and plain read-write bytes.
    repeat (6)
    begin
      v = rnd8();
      wr(8'hC8, v);
      rchk(8'hC8, v & 8'hFD);
      wr(8'hC8, 8'h00);
      wr(8'h8E, v);
      rchk(8'h8E, v & 8'h30);
      wr(8'hC9, v);
      rchk(8'hC9, 8'h00);
      for (int a = 8'hCA; a <= 8'hCD; a++)
      begin
        v = rnd8();
        wr(8'(a), v);
        rchk(8'(a), v);
      end
    end
    // Wrap corners, then random modes and values.
    one_tick(1'b0, 1'b0, 1'b1, 1'b0, 16'hFFFF, 16'h1234);
    one_tick(1'b0, 1'b1, 1'b1, 1'b1, 16'h00FF, 16'hABCD);
    one_tick(1'b1, 1'b0, 1'b1, 1'b0, 16'hFF7E, 16'h5A00);
    one_tick(1'b1, 1'b1, 1'b0, 1'b0, 16'h01FF, 16'h0000);
    repeat (12)
    begin
      v = rnd8();
      c16 = {rnd8() | {8{v[4]}}, rnd8() | {8{v[5]}}};
      r16 = {rnd8(), rnd8()};
      one_tick(v[0], v[1], v[2], v[3], c16, r16);
    end
    // Split low byte on the external clock while the high byte is stopped.
    v = rnd8();
    timer_irq_enable = 1'b1;
    wr(8'h8E, 8'h00);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'h3C);
    wr(8'hCA, v);
    wr(8'hC8, 8'h29);
    ext_div8_clk = 1'b1;
    repeat (6) idle();
    rchk(8'hCC, v);
    rchk(8'hCD, 8'h3C);
    rchk(8'hC8, 8'h69);
    chk("interrupt request", 8'h01, {7'h00, irq_req});
    ext_div8_clk = 1'b0;
    // Divide-by-12 source over 120 system clock edges, ten counting edges.
    wr(8'hC8, 8'h00);
    wr(8'h8E, 8'h00);
    wr(8'hCC, 8'h00);
    wr(8'hCD, 8'h00);
    wr(8'hC8, 8'h04);
    repeat (119) idle();
    wr(8'hC8, 8'h00);
    repeat (20) idle();
    rchk(8'hCC, 8'h0A);
    rchk(8'hCD, 8'h00);
    // External divided clock, five rising edges.
    wr(8'hC8, 8'h05);
    repeat (5)
    begin
      ext_div8_clk = 1'b1;
      repeat (4) idle();
      ext_div8_clk = 1'b0;
      repeat (4) idle();
    end
    wr(8'hC8, 8'h00);
    rchk(8'hCC, 8'h0F);
    // Capture on a falling edge of the external clock, timer held.
    c16 = {rnd8(), rnd8()};
    wr(8'h8E, 8'h10);
    wr(8'hCC, c16[7:0]);
    wr(8'hCD, c16[15:8]);
    wr(8'hC8, 8'h10);
    ext_div8_clk = 1'b1;
    repeat (6) idle();
    ext_div8_clk = 1'b0;
    repeat (12) idle();
    rchk(8'hCA, c16[7:0]);
    rchk(8'hCB, c16[15:8]);
    rchk(8'hC8, 8'h90);
    chk("interrupt request", 8'h01, {7'h00, irq_req});
    tally_and_finish();
  end
endmodule // art_timer_test
